/* design/fssi_blink.v */
`timescale 1ns/100ps
`include "fssi_regs.vh"

module fssi_blink #(
  parameter [22:0] TICK_CYC = `FSSI_BLINK_CYC
) (
  input wire clk,
  input wire rst,
  output reg tick,
  output reg flash,
  output reg single,
  output reg double
);

  reg [22:0] cnt_reg;
  reg [2:0] phase_reg;
  wire tick_next;

  assign tick_next = (cnt_reg == TICK_CYC - 23'h000001);

  // ----------------------------------------
  // Free-running tick and eight-tick frame
  // ----------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= 23'h000000;
      phase_reg <= 3'h0;
      tick <= 1'b0;
    end else begin
      tick <= tick_next;
      if (tick_next) begin
        cnt_reg <= 23'h000000;
        if (phase_reg == `FSSI_PHASE_LAST)
          phase_reg <= 3'h0;
        else
          phase_reg <= phase_reg + 3'h1;
      end else begin
        cnt_reg <= cnt_reg + 23'h000001;
      end
    end
  end

  // ----------------------------------------
  // Patterns
  // ----------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      flash <= 1'b0;
      single <= 1'b0;
      double <= 1'b0;
    end else begin
      flash <= ~phase_reg[0];
      single <= (phase_reg == 3'h0);
      double <= (phase_reg == 3'h0) || (phase_reg == `FSSI_PHASE_SECOND);
    end
  end

endmodule

/* design/fssi_regs.vh */
`ifndef FSSI_REGS_VH
`define FSSI_REGS_VH

// ----------------------------------------
// Slave states
// ----------------------------------------
`define FSSI_ST_INIT 2'h0
`define FSSI_ST_PREOP 2'h1
`define FSSI_ST_SAFEOP 2'h2
`define FSSI_ST_OP 2'h3

// ----------------------------------------
// Reset values
// ----------------------------------------
`define FSSI_RST_STATE 2'h0
`define FSSI_RST_UPSTREAM 1'h0

// ----------------------------------------
// Blink timing
// ----------------------------------------
// 200 ms per tick at 20 MHz
`define FSSI_BLINK_CYC 23'h3D0900
`define FSSI_PHASE_LAST 3'h7
`define FSSI_PHASE_SECOND 3'h2

`endif

/* design/fssi_state_ind.v */
`timescale 1ns/100ps
`include "fssi_regs.vh"

// Function
// - Four states, transitions commanded by master except fatal error to Init and watchdog to SafeOp
// - Power-up in Init, master advances
// - Traffic allowed per state, staged
// - Transmit data out read-only, receive in
// - Service data only on request
// - Service writes only to read/write variables
// - Run LED shows state or fatal
// - Error LED shows error class pattern
// - Link LED off, steady, or flashing
// - Two ports, one upstream, other forwards
module fssi_state_ind #(
  parameter [22:0] TICK_CYC = `FSSI_BLINK_CYC
) (
  input wire clk,
  input wire rst,
  input wire state_req_valid,
  input wire [1:0] state_req,
  input wire fatal_err,
  input wire cfg_invalid,
  input wire unsol_change,
  input wire wdog_timeout,
  input wire app_fail,
  input wire err_clear,
  input wire sdo_req,
  input wire sdo_write,
  input wire sdo_var_rw,
  input wire sdo_var_pdo,
  input wire txpdo_req,
  input wire [31:0] txpdo_meas,
  input wire rxpdo_valid,
  input wire [31:0] rxpdo_data,
  input wire [1:0] link_up,
  input wire [1:0] link_act,
  output reg [1:0] cur_state,
  output reg state_refused,
  output reg sdo_ok,
  output reg sdo_reject,
  output reg txpdo_valid,
  output reg [31:0] txpdo_data,
  output reg rxpdo_accept,
  output reg [31:0] setpoint,
  output reg upstream_port,
  output reg upstream_valid,
  output reg forward_en,
  output reg run_green,
  output reg run_red,
  output reg err_red,
  output reg [1:0] link_led
);

  wire tick;
  wire flash;
  wire single;
  wire double;
  reg unsol_reg;
  reg wdog_reg;
  reg [1:0] act_reg;
  reg [1:0] act_seen_reg;
  reg [1:0] state_next;
  reg refused_next;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function sdo_open;
    input [1:0] st;
    begin
      sdo_open = (st != `FSSI_ST_INIT);
    end
  endfunction

  function txpdo_open;
    input [1:0] st;
    begin
      txpdo_open = (st == `FSSI_ST_SAFEOP) || (st == `FSSI_ST_OP);
    end
  endfunction

  fssi_blink #(
    .TICK_CYC(TICK_CYC)
  ) fssi_blink_i (
    .clk(clk),
    .rst(rst),
    .tick(tick),
    .flash(flash),
    .single(single),
    .double(double)
  );

  // ----------------------------------------
  // State machine
  // ----------------------------------------
  always @* begin
    state_next = cur_state;
    refused_next = 1'b0;
    if (fatal_err) begin
      state_next = `FSSI_ST_INIT;
    end else if (wdog_timeout && (cur_state == `FSSI_ST_OP)) begin
      state_next = `FSSI_ST_SAFEOP;
    end else if (state_req_valid) begin
      // Up one step, or down to any lower state
      if ((state_req == cur_state + 2'h1) && (cur_state != `FSSI_ST_OP))
        state_next = state_req;
      else if (state_req <= cur_state)
        state_next = state_req;
      else
        refused_next = 1'b1;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cur_state <= `FSSI_RST_STATE;
      state_refused <= 1'b0;
    end else begin
      cur_state <= state_next;
      state_refused <= refused_next;
    end
  end

  // ----------------------------------------
  // Traffic gating
  // ----------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      sdo_ok <= 1'b0;
      sdo_reject <= 1'b0;
      txpdo_valid <= 1'b0;
      txpdo_data <= 32'h00000000;
      rxpdo_accept <= 1'b0;
      setpoint <= 32'h00000000;
    end else begin
      // Answered only per request, never cyclic
      sdo_ok <= 1'b0;
      sdo_reject <= 1'b0;
      if (sdo_req) begin
        if (!sdo_open(cur_state))
          sdo_reject <= 1'b1;
        else if (sdo_write && (!sdo_var_rw || sdo_var_pdo))
          sdo_reject <= 1'b1;
        else
          sdo_ok <= 1'b1;
      end
      txpdo_valid <= txpdo_req && txpdo_open(cur_state);
      if (txpdo_req && txpdo_open(cur_state))
        txpdo_data <= txpdo_meas;
      rxpdo_accept <= rxpdo_valid && (cur_state == `FSSI_ST_OP);
      if (rxpdo_valid && (cur_state == `FSSI_ST_OP))
        setpoint <= rxpdo_data;
    end
  end

  // ----------------------------------------
  // Port roles
  // ----------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      upstream_port <= `FSSI_RST_UPSTREAM;
      upstream_valid <= 1'b0;
      forward_en <= 1'b0;
    end else begin
      if (!upstream_valid) begin
        if (link_up[0]) begin
          upstream_port <= 1'b0;
          upstream_valid <= 1'b1;
        end else if (link_up[1]) begin
          upstream_port <= 1'b1;
          upstream_valid <= 1'b1;
        end
      end else if (!link_up[upstream_port]) begin
        upstream_valid <= 1'b0;
      end
      forward_en <= upstream_valid && link_up[upstream_port] &&
                    link_up[~upstream_port];
    end
  end

  // ----------------------------------------
  // Error latches, set wins over clear
  // ----------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      unsol_reg <= 1'b0;
      wdog_reg <= 1'b0;
      act_reg <= 2'h0;
      act_seen_reg <= 2'h0;
    end else begin
      if (unsol_change)
        unsol_reg <= 1'b1;
      else if (err_clear)
        unsol_reg <= 1'b0;
      if (wdog_timeout)
        wdog_reg <= 1'b1;
      else if (err_clear)
        wdog_reg <= 1'b0;
      // Activity gathered over one tick window
      if (tick) begin
        act_seen_reg <= act_reg | link_act;
        act_reg <= link_act;
      end else begin
        act_reg <= act_reg | link_act;
      end
    end
  end

  // ----------------------------------------
  // Indicators
  // ----------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      run_green <= 1'b0;
      run_red <= 1'b0;
      err_red <= 1'b0;
      link_led <= 2'h0;
    end else begin
      run_red <= fatal_err;
      if (fatal_err) begin
        run_green <= 1'b0;
      end else begin
        case (cur_state)
          `FSSI_ST_OP: run_green <= 1'b1;
          `FSSI_ST_PREOP: run_green <= flash;
          `FSSI_ST_SAFEOP: run_green <= single;
          default: run_green <= 1'b0;
        endcase
      end
      if (app_fail)
        err_red <= 1'b1;
      else if (wdog_reg)
        err_red <= double;
      else if (unsol_reg)
        err_red <= single;
      else if (cfg_invalid)
        err_red <= flash;
      else
        err_red <= 1'b0;
      link_led[0] <= link_up[0] && (!act_seen_reg[0] || flash);
      link_led[1] <= link_up[1] && (!act_seen_reg[1] || flash);
    end
  end

endmodule

/* verification/fssi_master.sv */
`timescale 1ns/100ps
module fssi_master (
  input logic clk,
  output logic state_req_valid,
  output logic [1:0] state_req,
  output logic sdo_req,
  output logic sdo_write,
  output logic sdo_var_rw,
  output logic sdo_var_pdo
);
  // --------------------
  // Master commands
  // --------------------
  initial begin
    {state_req_valid, state_req, sdo_req, sdo_write} = 5'h00;
    {sdo_var_rw, sdo_var_pdo} = 2'h0;
  end
  task cmd(input logic [1:0] s);
    @(posedge clk);
    state_req_valid <= 1'h1;
    state_req <= s;
    @(posedge clk);
    state_req_valid <= 1'h0;
    state_req <= ~s;
  endtask
  // Service request for one cycle, with write, read/write and mapped flags
  task sdo(input logic w, input logic rw, input logic pdo);
    @(posedge clk);
    {sdo_req, sdo_write, sdo_var_rw, sdo_var_pdo} <= {1'h1, w, rw, pdo};
    @(posedge clk);
    sdo_req <= 1'h0;
    sdo_write <= ~w;
  endtask
endmodule

/* verification/fssi_state_ind_props.sv */
`timescale 1ns/100ps
module fssi_state_ind_props (
  input logic clk,
  input logic rst,
  input logic state_req_valid,
  input logic fatal_err,
  input logic wdog_timeout,
  input logic sdo_req,
  input logic sdo_write,
  input logic sdo_var_rw,
  input logic sdo_var_pdo,
  input logic txpdo_req,
  input logic [1:0] cur_state,
  input logic sdo_reject,
  input logic txpdo_valid,
  input logic rxpdo_accept,
  input logic run_green,
  input logic run_red
);
  // --------------------
  // Port relations
  // --------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_fatal_to_init:
    assert property (fatal_err |=> cur_state == 2'h0) else $error("no init");
  a_sdo_init_rej:
    assert property (sdo_req && cur_state == 2'h0 |=> sdo_reject)
      else $error("sdo in init");
  a_sdo_wr_rej:
    assert property (sdo_req && sdo_write && (!sdo_var_rw || sdo_var_pdo)
      |=> sdo_reject) else $error("bad write taken");
  a_tx_gate:
    assert property (txpdo_req && cur_state[1] && !fatal_err |=> txpdo_valid)
      else $error("tx missing");
  a_tx_block:
    assert property (txpdo_valid |-> $past(cur_state[1])) else $error("tx");
  a_rx_op_only:
    assert property (rxpdo_accept |-> $past(cur_state) == 2'h3)
      else $error("rx outside op");
  a_state_step:
    assert property (cur_state != $past(cur_state) && !$past(rst)
      && !$past(fatal_err) && !$past(wdog_timeout) |-> $past(state_req_valid)
      && cur_state <= $past(cur_state) + 3'h1) else $error("bad step");
  a_run_red_on:
    assert property (fatal_err [*4] |-> run_red && !run_green)
      else $error("run red");
  a_op_green:
    assert property ((cur_state == 2'h3 && !fatal_err) [*3] |-> run_green)
      else $error("op green");
  c_tx: cover property (txpdo_valid);
  c_rx: cover property (rxpdo_accept);
  c_rej: cover property (sdo_reject);
endmodule

bind fssi_state_ind fssi_state_ind_props fssi_state_ind_props_i (.*);

/* verification/fssi_state_ind_tb.sv */
`timescale 1ns/100ps
module fssi_state_ind_tb;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic fatal_err = 1'h0, cfg_invalid = 1'h0, unsol_change = 1'h0;
  logic wdog_timeout = 1'h0, app_fail = 1'h0, err_clear = 1'h0;
  logic txpdo_req = 1'h0, rxpdo_valid = 1'h0;
  logic [31:0] txpdo_meas = 32'h0, rxpdo_data = 32'hA5A5_0000;
  logic [31:0] exp_sp = 32'h0;
  logic [1:0] link_up = 2'h0, link_act = 2'h0;
  wire state_req_valid, sdo_req, sdo_write, sdo_var_rw, sdo_var_pdo;
  wire [1:0] state_req, cur_state, link_led;
  wire state_refused, sdo_ok, sdo_reject, txpdo_valid, rxpdo_accept;
  wire [31:0] txpdo_data, setpoint;
  wire upstream_port, upstream_valid, forward_en;
  wire run_green, run_red, err_red;
  int n_fail = 0;
  int checked = 0;
  localparam int FRAME = 32;
  // --------------------
  // Harness
  // --------------------
  always #25 clk = ~clk;
  fssi_state_ind #(.TICK_CYC(23'h4)) fssi_state_ind_i (.*);
  fssi_master fssi_master_i (.*);
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task finish_test;
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // --------------------
  // Scenarios
  // --------------------
  task pdo_tx(input logic ok);
    @(posedge clk);
    txpdo_req <= 1'h1;
    txpdo_meas <= txpdo_meas + 32'h1111_1111;
    @(posedge clk);
    txpdo_req <= 1'h0;
    #1 chk(txpdo_valid, ok);
    if (ok) chk(txpdo_data, txpdo_meas);
  endtask
  task pdo_rx(input logic ok);
    @(posedge clk);
    rxpdo_valid <= 1'h1;
    rxpdo_data <= rxpdo_data + 32'h0F0F_0F0F;
    @(posedge clk);
    rxpdo_valid <= 1'h0;
    #1 if (ok) exp_sp = rxpdo_data;
    chk(rxpdo_accept, ok);
    chk(setpoint, exp_sp);
  endtask
  task t_states;
    fssi_master_i.cmd(2'h2);
    #1 chk(state_refused, 1'h1);
    chk(cur_state, 2'h0);
    fssi_master_i.sdo(1'h0, 1'h1, 1'h0);
    #1 chk(sdo_reject, 1'h1);
    fssi_master_i.cmd(2'h1);
    #1 chk(cur_state, 2'h1);
    fssi_master_i.sdo(1'h0, 1'h0, 1'h0);
    #1 chk(sdo_ok, 1'h1);
    pdo_tx(1'h0);
    fssi_master_i.cmd(2'h2);
    pdo_tx(1'h1);
    pdo_rx(1'h0);
    fssi_master_i.cmd(2'h3);
    #1 chk(cur_state, 2'h3);
    pdo_rx(1'h1);
    repeat (4) @(posedge clk);
    #1 chk(run_green, 1'h1);
  endtask
  function automatic logic led_of(input int sel);
    if (sel == 0) return run_green;
    if (sel == 1) return err_red;
    return link_led[0];
  endfunction
  // Rising edges of one LED over one blink frame
  task count_rises(input int sel, output int n);
    logic prev;
    n = 0;
    @(posedge clk);
    #1 prev = led_of(sel);
    repeat (FRAME) begin
      @(posedge clk);
      #1 if (led_of(sel) && !prev) n++;
      prev = led_of(sel);
    end
  endtask
  task t_run_led;
    int n;
    fssi_master_i.cmd(2'h1);
    count_rises(0, n);
    chk(n, 4);
    fssi_master_i.cmd(2'h2);
    count_rises(0, n);
    chk(n, 1);
    fssi_master_i.cmd(2'h3);
    #1 chk(cur_state, 2'h3);
  endtask
  task t_err;
    int n;
    @(posedge clk) wdog_timeout <= 1'h1;
    @(posedge clk) wdog_timeout <= 1'h0;
    #1 chk(cur_state, 2'h2);
    count_rises(1, n);
    chk(n, 2);
    @(posedge clk) {unsol_change, err_clear} <= 2'h3;
    @(posedge clk) {unsol_change, err_clear} <= 2'h0;
    count_rises(1, n);
    chk(n, 1);
    @(posedge clk) {err_clear, cfg_invalid} <= 2'h3;
    @(posedge clk) err_clear <= 1'h0;
    count_rises(1, n);
    chk(n, 4);
    @(posedge clk) cfg_invalid <= 1'h0;
    count_rises(1, n);
    chk(n, 0);
    chk(err_red, 1'h0);
  endtask
  task t_sdo_wr;
    for (int i = 0; i < 3; i++) begin
      fssi_master_i.sdo(1'h1, i != 0, i == 1);
      #1 chk(sdo_ok, i == 2);
      chk(sdo_reject, i != 2);
    end
  endtask
  task t_fatal;
    @(posedge clk) fatal_err <= 1'h1;
    repeat (4) @(posedge clk);
    #1 chk(cur_state, 2'h0);
    chk({run_red, run_green}, 2'h2);
    @(posedge clk) fatal_err <= 1'h0;
    @(posedge clk) app_fail <= 1'h1;
    repeat (3) @(posedge clk);
    #1 chk(err_red, 1'h1);
    @(posedge clk) app_fail <= 1'h0;
  endtask
  task t_link;
    int n;
    @(posedge clk) link_up <= 2'h1;
    repeat (3) @(posedge clk);
    #1 chk({upstream_valid, upstream_port, forward_en}, 3'h4);
    @(posedge clk) link_up <= 2'h3;
    repeat (20) @(posedge clk);
    #1 chk(forward_en, 1'h1);
    chk(link_led, 2'h3);
    @(posedge clk) link_act <= 2'h1;
    repeat (10) @(posedge clk);
    count_rises(2, n);
    chk(n, 4);
    @(posedge clk) link_act <= 2'h0;
    repeat (12) @(posedge clk);
    #1 chk(link_led, 2'h3);
    @(posedge clk) link_up <= 2'h0;
    repeat (3) @(posedge clk);
    #1 chk({upstream_valid, link_led}, 3'h0);
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'h0;
    #1 chk({cur_state, run_green, err_red, link_led}, 6'h00);
    t_states;
    t_run_led;
    t_sdo_wr;
    t_err;
    t_fatal;
    t_link;
    finish_test;
  end
  initial begin
    #100000;
    n_fail++;
    finish_test;
  end
endmodule
